/* File: rtl/owp_cfg.svh */
// constants of the odd word count framer: frame codes, crc setup, dword halves
// assumed to be included by the package and the framer only
`ifndef OWP_CFG_SVH
`define OWP_CFG_SVH

// frame type codes sit in the low byte of a frame's first dword (arbitrary values)
`define OWP_FT_ACTIVATE 8'h01
`define OWP_FT_PIO_SETUP 8'h02
`define OWP_FT_FP_SETUP 8'h03
`define OWP_FT_DATA 8'h04
`define OWP_FT_BITS 7:0
// frame check: crc-32 polynomial and seed
`define OWP_CRC_POLY 32'h04C11DB7
`define OWP_CRC_SEED 32'hFFFFFFFF
// 16-bit halves of a dword: earlier word low, later word high
`define OWP_LO 15:0
`define OWP_HI 31:16
`define OWP_PAD 16'h0000
// buffer entry layout {eof, sof, dword}
`define OWP_ENT_EOF 33
`define OWP_ENT_SOF 32
`define OWP_ENT_DW 31:0
`define OWP_BUF_FULL 2'h2
`define OWP_BUF_ONE 2'h1
`define OWP_BUF_EMPTY 2'h0

`endif

/* File: rtl/owp_framer.sv */
// device-side framer for odd 16-bit word counts over a 32-bit dword link
// assumes link and device core run on mclk; link strips crc of received frames
//
// Function
// - legacy dma write: device sends dma activate once command is processed.
// - sender's frame crc covers whole frame including pad half.
// - receiver uses expected count and drops pad in last dword's upper half.
// - pio read: one data frame, last dword's upper half padded.
// - pio write: device sends pio setup carrying the odd word count.
// - first-party dma: device sends setup with base address and odd count.
// - first-party dma write: one data frame after setup, last dword's upper half zero.
`timescale 1ns/100ps
`include "owp_cfg.svh"
`default_nettype none
module owp_framer
  import owp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  input  wire owp_op_t     cmd_op,
  input  wire logic [15:0] cmd_count,
  input  wire logic [31:0] cmd_addr,
  output logic             cmd_ready,
  output logic             done,
  input  wire logic        src_valid,
  input  wire logic [15:0] src_word,
  output logic             src_ready,
  output logic             tx_valid,
  output logic [31:0]      tx_data,
  output logic             tx_sof,
  output logic             tx_eof,
  input  wire logic        tx_ready,
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_sof,
  output logic             rx_ready,
  output logic             snk_valid,
  output logic [15:0]      snk_word,
  input  wire logic        snk_ready
);

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      if (r[31] ^ d[i]) r = {r[30:0], 1'b0} ^ `OWP_CRC_POLY;
      else r = {r[30:0], 1'b0};
    end
    return r;
  endfunction

  // index of the last header dword of each frame kind
  function automatic logic [1:0] hdr_last(input owp_frame_t f);
    unique case (f)
      FR_ACT:   return 2'h0;
      FR_DATA:  return 2'h0;
      FR_PSET:  return 2'h1;
      FR_FPSET: return 2'h2;
    endcase
  endfunction

  function automatic logic [31:0] hdr_dword(input owp_frame_t f, input logic [1:0] i,
                                            input logic [31:0] a, input logic [15:0] n);
    logic [31:0] w;
    w = '0;
    if (i == 2'h0) begin
      unique case (f)
        FR_ACT:   w[`OWP_FT_BITS] = `OWP_FT_ACTIVATE;
        FR_PSET:  w[`OWP_FT_BITS] = `OWP_FT_PIO_SETUP;
        FR_FPSET: w[`OWP_FT_BITS] = `OWP_FT_FP_SETUP;
        FR_DATA:  w[`OWP_FT_BITS] = `OWP_FT_DATA;
      endcase
    end else if (f == FR_FPSET && i == 2'h1) begin
      w = a;
    end else begin
      w[`OWP_LO] = n;
    end
    return w;
  endfunction

  owp_state_t  st_q, st_d;
  owp_op_t     op_q, op_d;
  owp_frame_t  fr_q, fr_d;
  logic [1:0]  idx_q, idx_d;
  logic [15:0] cnt_q, cnt_d;
  logic [31:0] addr_q, addr_d;
  logic [15:0] rem_q, rem_d;
  logic [15:0] lo_q, lo_d;
  logic        have_lo_q, have_lo_d;
  logic [31:0] crc_q, crc_d;
  logic        done_q, done_d;
  logic        cmd_ready_q, cmd_ready_d;
  logic        src_ready_q, src_ready_d;
  logic        rx_ready_q, rx_ready_d;
  logic [31:0] hd_q, hd_d;
  logic        hv_q, hv_d;
  logic        half_q, half_d;
  logic        snk_valid_q, snk_valid_d;
  logic [15:0] snk_word_q, snk_word_d;
  logic        push;
  logic [33:0] push_ent;
  logic        room;
  logic [33:0] slot0_q, slot0_d, slot1_q, slot1_d;
  logic [1:0]  bcnt_q, bcnt_d;
  logic        tx_valid_q, tx_valid_d;
  logic        pop;

  assign room = (bcnt_q != `OWP_BUF_FULL);
  assign pop  = tx_valid_q && tx_ready;

  always_comb begin
    st_d = st_q;  op_d = op_q;  fr_d = fr_q;  idx_d = idx_q;
    cnt_d = cnt_q;  addr_d = addr_q;  rem_d = rem_q;
    lo_d = lo_q;  have_lo_d = have_lo_q;  crc_d = crc_q;
    hd_d = hd_q;  hv_d = hv_q;  half_d = half_q;
    snk_valid_d = snk_valid_q && !snk_ready;
    snk_word_d = snk_word_q;
    done_d = 1'b0;
    push = 1'b0;
    push_ent = '0;
    unique case (st_q)
      ST_IDLE: begin
        if (cmd_valid && cmd_ready_q) begin
          op_d = cmd_op;  cnt_d = cmd_count;  addr_d = cmd_addr;  rem_d = cmd_count;
          idx_d = 2'h0;  crc_d = `OWP_CRC_SEED;  have_lo_d = 1'b0;
          st_d = ST_HDR;
          unique case (cmd_op)
            OP_LDMA_WR: fr_d = FR_ACT;
            OP_PIO_RD:  fr_d = FR_DATA;
            OP_PIO_WR:  fr_d = FR_PSET;
            default:    fr_d = FR_FPSET;
          endcase
        end
      end
      ST_HDR: begin
        if (room) begin
          push = 1'b1;
          push_ent = {1'b0, idx_q == 2'h0, hdr_dword(fr_q, idx_q, addr_q, cnt_q)};
          crc_d = crc_step(crc_q, push_ent[`OWP_ENT_DW]);
          if (idx_q == hdr_last(fr_q)) begin
            idx_d = 2'h0;
            if (fr_q == FR_DATA && rem_q != 16'h0) st_d = ST_PACK;
            else st_d = ST_CRC;
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
      ST_PACK: begin
        // src_ready_q only stands while the buffer has room, so a push here never stalls
        if (src_valid && src_ready_q) begin
          rem_d = rem_q - 16'h1;
          if (have_lo_q) begin
            push = 1'b1;
            push_ent = {2'b00, src_word, lo_q};
            have_lo_d = 1'b0;
          end else if (rem_q == 16'h1) begin
            push = 1'b1;
            push_ent = {2'b00, `OWP_PAD, src_word};
          end else begin
            lo_d = src_word;
            have_lo_d = 1'b1;
          end
          if (push) crc_d = crc_step(crc_q, push_ent[`OWP_ENT_DW]);
          if (rem_d == 16'h0) st_d = ST_CRC;
        end
      end
      ST_CRC: begin
        if (room) begin
          push = 1'b1;
          push_ent = {1'b1, 1'b0, crc_q};
          crc_d = `OWP_CRC_SEED;
          rem_d = cnt_q;
          if (fr_q == FR_FPSET && op_q == OP_FP_WR) begin
            fr_d = FR_DATA;
            st_d = ST_HDR;
          end else if (op_q == OP_PIO_RD || op_q == OP_FP_WR) begin
            st_d = ST_IDLE;
            done_d = 1'b1;
          end else begin
            st_d = ST_RECV;
            hv_d = 1'b0;
          end
        end
      end
      ST_RECV: begin
        // frame headers are dropped; the host may split data over several frames
        if (rx_valid && rx_ready_q && !rx_sof) begin
          hd_d = rx_data;
          hv_d = 1'b1;
          half_d = 1'b0;
        end
        if (hv_q && (!snk_valid_q || snk_ready)) begin
          snk_valid_d = 1'b1;
          snk_word_d = half_q ? hd_q[`OWP_HI] : hd_q[`OWP_LO];
          rem_d = rem_q - 16'h1;
          if (half_q || rem_q == 16'h1) hv_d = 1'b0;
          else half_d = 1'b1;
        end
        if (rem_q == 16'h0 && !hv_q) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    cmd_ready_d = (st_d == ST_IDLE);
    rx_ready_d  = (st_d == ST_RECV) && !hv_d && (rem_d != 16'h0);
  end

  // two-entry buffer toward the link: head always in slot0 so the outputs are flops
  always_comb begin
    slot0_d = slot0_q;
    slot1_d = slot1_q;
    bcnt_d = bcnt_q;
    unique case ({push, pop})
      2'b01: begin
        slot0_d = slot1_q;
        bcnt_d = bcnt_q - 2'h1;
      end
      2'b10: begin
        if (bcnt_q == `OWP_BUF_EMPTY) slot0_d = push_ent;
        else slot1_d = push_ent;
        bcnt_d = bcnt_q + 2'h1;
      end
      2'b11: begin
        if (bcnt_q == `OWP_BUF_ONE) begin
          slot0_d = push_ent;
        end else begin
          slot0_d = slot1_q;
          slot1_d = push_ent;
        end
      end
      default: bcnt_d = bcnt_q;
    endcase
    tx_valid_d = (bcnt_d != `OWP_BUF_EMPTY);
  end

  assign src_ready_d = (st_d == ST_PACK) && (rem_d != 16'h0) && (bcnt_d != `OWP_BUF_FULL);

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= ST_IDLE;  op_q <= OP_LDMA_WR;  fr_q <= FR_ACT;  idx_q <= 2'h0;
      cnt_q <= 16'h0;  addr_q <= 32'h0;  rem_q <= 16'h0;
      lo_q <= 16'h0;  have_lo_q <= 1'b0;  crc_q <= `OWP_CRC_SEED;
      done_q <= 1'b0;  cmd_ready_q <= 1'b0;  src_ready_q <= 1'b0;  rx_ready_q <= 1'b0;
      hd_q <= 32'h0;  hv_q <= 1'b0;  half_q <= 1'b0;
      snk_valid_q <= 1'b0;  snk_word_q <= 16'h0;
    end else begin
      st_q <= st_d;  op_q <= op_d;  fr_q <= fr_d;  idx_q <= idx_d;
      cnt_q <= cnt_d;  addr_q <= addr_d;  rem_q <= rem_d;
      lo_q <= lo_d;  have_lo_q <= have_lo_d;  crc_q <= crc_d;
      done_q <= done_d;  cmd_ready_q <= cmd_ready_d;
      src_ready_q <= src_ready_d;  rx_ready_q <= rx_ready_d;
      hd_q <= hd_d;  hv_q <= hv_d;  half_q <= half_d;
      snk_valid_q <= snk_valid_d;  snk_word_q <= snk_word_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      slot0_q <= '0;
      slot1_q <= '0;
      bcnt_q <= `OWP_BUF_EMPTY;
      tx_valid_q <= 1'b0;
    end else begin
      slot0_q <= slot0_d;
      slot1_q <= slot1_d;
      bcnt_q <= bcnt_d;
      tx_valid_q <= tx_valid_d;
    end
  end

  assign cmd_ready = cmd_ready_q;
  assign done      = done_q;
  assign src_ready = src_ready_q;
  assign tx_valid  = tx_valid_q;
  assign tx_data   = slot0_q[`OWP_ENT_DW];
  assign tx_sof    = slot0_q[`OWP_ENT_SOF];
  assign tx_eof    = slot0_q[`OWP_ENT_EOF];
  assign rx_ready  = rx_ready_q;
  assign snk_valid = snk_valid_q;
  assign snk_word  = snk_word_q;

endmodule // owp_framer
`default_nettype wire

/* File: rtl/owp_pkg.sv */
// types shared by the odd word count framer
// assumes owp_cfg.svh is on the include path
`include "owp_cfg.svh"
package owp_pkg;
  typedef enum logic [2:0] {
    OP_LDMA_WR, OP_PIO_RD, OP_PIO_WR, OP_FP_RD, OP_FP_WR
  } owp_op_t;
  typedef enum logic [1:0] { FR_ACT, FR_PSET, FR_FPSET, FR_DATA } owp_frame_t;
  typedef enum logic [2:0] { ST_IDLE, ST_HDR, ST_PACK, ST_CRC, ST_RECV } owp_state_t;
endpackage

/* File: tb/owp_framer_monitor.sv */
// assertions on the framer ports: command, frame starts, holds
// bound into owp_framer; one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module owp_framer_chk (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        done,
  input wire logic        tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic        tx_sof,
  input wire logic        tx_eof,
  input wire logic        tx_ready,
  input wire logic        rx_valid,
  input wire logic        rx_sof,
  input wire logic        rx_ready,
  input wire logic        snk_valid,
  input wire logic [15:0] snk_word,
  input wire logic        snk_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // a frame left in the buffer by the previous command may still stand at the head
  property p_hdr; cmd_valid && cmd_ready && !tx_valid |-> ##2 tx_valid && tx_sof; endproperty
  a_hdr: assert property (p_hdr) else $error("late frame start");
  property p_busy; cmd_valid && cmd_ready |=> !cmd_ready [*2]; endproperty
  a_busy: assert property (p_busy) else $error("ready during command");
  // a new command may be taken at the edge that sees done, so only that edge is checked
  property p_done; done |-> cmd_ready ##1 !done; endproperty
  a_done: assert property (p_done) else $error("bad done pulse");
  property p_txh; tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_sof, tx_eof}); endproperty
  a_txh: assert property (p_txh) else $error("tx changed in stall");
  property p_type; tx_valid && tx_sof |-> tx_data[7:0] inside {[8'h01:8'h04]}; endproperty
  a_type: assert property (p_type) else $error("bad frame type");
  property p_next; tx_valid && tx_ready && tx_eof |=> !tx_valid || tx_sof; endproperty
  a_next: assert property (p_next) else $error("no start after end");
  property p_snk; snk_valid && !snk_ready |=> snk_valid && $stable(snk_word); endproperty
  a_snk: assert property (p_snk) else $error("word changed in stall");
  // a taken data dword is held until both halves, or the lone last word of an odd count, are out, so rx closes at once
  property p_rxb; rx_valid && rx_ready && !rx_sof |=> !rx_ready; endproperty
  a_rxb: assert property (p_rxb) else $error("rx open while held");
endmodule // owp_framer_chk
bind owp_framer owp_framer_chk owp_framer_chk_i (.*);
`default_nettype wire

/* File: tb/owp_host_model.sv */
// host end of the link: records sent dwords, answers setup and activate frames with data
// assumes the bench loads words before the setup frame closes
`timescale 1ns/100ps
`default_nettype none
module owp_host_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_sof,
  input  wire logic        tx_eof,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [31:0]      rx_data,
  output logic             rx_sof,
  input  wire logic        rx_ready
);
  logic [33:0] got[$];
  logic [15:0] words[$];
  logic [32:0] out_q[$];
  logic [7:0]  ftype;
  logic [15:0] w0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 32'h0;
    rx_sof = 1'b0;
    ftype = 8'h0;
  end
  always @(posedge mclk) begin
    tx_ready <= !stall;
    if (reset) begin
      rx_valid <= 1'b0;
      out_q.delete();
    end else begin
      if (tx_valid && tx_ready) begin
        got.push_back({tx_eof, tx_sof, tx_data});
        if (tx_sof)
          ftype = tx_data[7:0];
        // data only once the device's setup or activate frame has closed
        if (tx_eof && ftype != 8'h04 && words.size() > 0) begin
          out_q.push_back({1'b1, 32'h4});
          while (words.size() > 0) begin
            w0 = words.pop_front();
            out_q.push_back({1'b0, words.size() > 0 ? words.pop_front() : 16'h0000, w0});
          end
        end
      end
      if (!rx_valid || rx_ready) begin
        rx_valid <= out_q.size() > 0;
        // idle data inverts so a stale dword never looks valid
        {rx_sof, rx_data} <= out_q.size() > 0 ? out_q.pop_front() : {1'b0, ~rx_data};
      end
    end
  end
endmodule // owp_host_model
`default_nettype wire

/* File: tb/test_odd_word_count_padding.sv */
// bench: every operation at counts 1, 7 and 6 against a queue model
// assumes owp_pkg compiled first; host end is owp_host_model
`timescale 1ns/100ps
`default_nettype none
module test_odd_word_count_padding
  import owp_pkg::*;
;
  logic mclk = 0, reset = 1, cmd_valid = 0, src_valid = 0, snk_ready = 0, stall = 0;
  owp_op_t cmd_op = OP_LDMA_WR;
  logic [15:0] cmd_count = 0, src_word = 0, snk_word;
  logic [31:0] cmd_addr = 0, tx_data, rx_data;
  logic cmd_ready, done, src_ready, tx_valid, tx_sof, tx_eof, tx_ready;
  logic rx_valid, rx_sof, rx_ready, snk_valid;
  integer seed = 32'h2221;
  int bad_count = 0, check_count = 0, cyc = 0, si = 0;
  logic [15:0] sq[$], rq[$], rxe[$];
  logic [33:0] exq[$];
  owp_framer owp_framer_i (.*);
  owp_host_model owp_host_model_i (.*);
  initial forever #12.5 mclk = ~mclk;
  task automatic tally_and_finish();
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  // one expected frame: sof on first dword, crc dword with eof at the end
  task automatic frame(input logic [31:0] d[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (d[i]) begin
      exq.push_back({1'b0, i == 0, d[i]});
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i][b]) ? 32'h04C11DB7 : 32'h0);
    end
    exq.push_back({2'h2, c});
  endtask
  task automatic run(input owp_op_t op, input int n);
    logic [31:0] d[$];
    logic [31:0] a;
    logic [15:0] wq[$];
    int k, b;
    a = $random(seed);
    for (k = 0; k < n; k++)
      wq.push_back(16'($random(seed)));
    d.push_back(32'h4);
    for (k = 0; k < n; k += 2)
      d.push_back({k + 1 < n ? wq[k + 1] : 16'h0000, wq[k]});
    exq = {};
    rq = {};
    rxe = {};
    si = 0;
    owp_host_model_i.got = {};
    case (op)
      OP_LDMA_WR: frame('{32'h1});
      OP_PIO_WR: frame('{32'h2, {16'h0, 16'(n)}});
      OP_PIO_RD: frame(d);
      default: frame('{32'h3, a, {16'h0, 16'(n)}});
    endcase
    if (op == OP_FP_WR)
      frame(d);
    if (op inside {OP_PIO_RD, OP_FP_WR})
      sq = wq;
    else begin
      rxe = wq;
      owp_host_model_i.words = wq;
    end
    while (cmd_ready !== 1'b1)
      @(posedge mclk);
    cmd_op <= op;
    cmd_count <= 16'(n);
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (k = 0; k < 2000 && done !== 1'b1; k++)
      @(posedge mclk);
    check(done === 1'b1, "no done");
    // stalls on both sides may leave words in flight after done
    repeat (40) @(posedge mclk);
    sq = {};
    check(owp_host_model_i.got.size() == exq.size(), "frame size");
    foreach (exq[i]) check(owp_host_model_i.got[i] === exq[i], "tx dword");
    check(rq.size() == rxe.size(), "word count");
    foreach (rxe[i]) check(rq[i] === rxe[i], "rx word");
    // host unpacks low half first and drops the pad half once its count runs out
    b = op == OP_FP_WR ? 5 : 1;
    for (k = 0; k < n && op inside {OP_PIO_RD, OP_FP_WR}; k++)
      check(owp_host_model_i.got[b + k / 2][16 * k[0] +: 16] === wq[k], "host");
    $display("done op %0d count %0d", op, n);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (src_valid && src_ready)
      si++;
    src_valid <= si < sq.size();
    src_word <= si < sq.size() ? sq[si] : 16'h0000;
    snk_ready <= 1'($random(seed));
    stall <= 1'($random(seed));
    if (snk_valid && snk_ready)
      rq.push_back(snk_word);
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int o = 0; o < 5; o++)
      for (int j = 0; j < 3; j++)
        run(owp_op_t'(o), j == 0 ? 1 : 8 - j);
    tally_and_finish();
  end
endmodule // test_odd_word_count_padding
`default_nettype wire
